// >>> src/spidg_map.svh
`ifndef SPIDG_MAP_SVH
`define SPIDG_MAP_SVH

// frame layout
`define SPIDG_FRAME_BITS 40
`define SPIDG_DATA_BITS 32
`define SPIDG_ADDR_BITS 7
`define SPIDG_WR_BIT 39
`define SPIDG_ADDR_HI 38
`define SPIDG_ADDR_LO 32
`define SPIDG_CNT_W 6
`define SPIDG_CNT_FULL 6'h28

// status byte positions
`define SPIDG_ST_STOP_R 7
`define SPIDG_ST_STOP_L 6
`define SPIDG_ST_POS 5
`define SPIDG_ST_VEL 4
`define SPIDG_ST_STILL 3
`define SPIDG_ST_STALL 2
`define SPIDG_ST_DRVERR 1
`define SPIDG_ST_RESET 0

// source bit positions
`define SPIDG_MS_STOP_R 1
`define SPIDG_MS_STOP_L 0
`define SPIDG_MS_POS 9
`define SPIDG_MS_VEL 8
`define SPIDG_DS_STILL 31
`define SPIDG_DS_STALL 24
`define SPIDG_GS_DRVERR 1
`define SPIDG_GS_RESET 0

// global status register address
`define SPIDG_GLOBAL_STATUS_WORD_ADDR 7'h01

// reset values
`define SPIDG_RST_FRAME 40'h00_0000_0000
`define SPIDG_RST_DATA 32'h0000_0000
`define SPIDG_RST_STATUS 8'h00

// buffering
`define SPIDG_FIFO_DEPTH 8
`define SPIDG_OUTST_W 4

`endif

// >>> src/spidg_pkg.sv
`default_nettype none
package spidg_pkg;
  typedef logic [39:0] spidg_frame_t;
  typedef logic [31:0] spidg_word_t;
  typedef logic [7:0] spidg_status_t;
  typedef logic [6:0] spidg_addr_t;
endpackage
`default_nettype wire

// >>> src/spidg_port.sv
// Operation
// - one 40-bit frame: address byte, 32 data, MSB first
// - every register moves as full 32-bit word
// - bit 39 high writes, low reads; 7-bit address
// - 40-bit response shifted out every frame
// - after read, response holds addressed register contents, zero when rsp_hit is low
// - after write, response echoes received write data
// - read frame data bits ignored, never stored
// - response bits 39..32 carry status byte
// - status captured at access end, shown next frame
// - status 7/6 are right/left stop switches
// - status 5/4 are position/velocity reached
// - status 3/2 are standstill and stall flag
// - status 1/0 global flags, cleared by reading
// - values right aligned, two's complement, integer fields
// - sample at rising edge, drive after falling edge
// - at select rise, last 40 bits form command
// - surplus bits reappear on output 40 clocks later
`include "spidg_map.svh"
`default_nettype none

// ----------------------------------------
// command fifo
// ----------------------------------------
module spidg_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      case ({push, pop})
        2'b10: count_ff <= count_ff + 1'b1;
        2'b01: count_ff <= count_ff - 1'b1;
        default: count_ff <= count_ff;
      endcase
    end
  end
endmodule

// ----------------------------------------
// datagram port top
// ----------------------------------------
module spidg_port (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic frame_select_n,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_write,
  output logic [6:0] cmd_addr,
  output logic [31:0] cmd_data,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic rsp_hit,
  input wire logic [31:0] rsp_data,
  input wire logic [9:0] motion_status_word,
  input wire logic [31:0] driver_status_word,
  input wire logic [1:0] global_status_word,
  output logic global_status_clear,
  output logic frame_dropped,
  output logic port_busy
);

  // ----------------------------------------
  // link domain: shift register
  // ----------------------------------------
  spidg_pkg::spidg_frame_t shift_ff;
  logic [`SPIDG_CNT_W-1:0] bit_cnt_ff;
  logic sdo_ff;
  logic link_rst;
  spidg_pkg::spidg_frame_t resp_ff;
  logic full_ff;

  // counter is cleared by the frame's own select, no sck edge needed
  assign link_rst = !resetn || frame_select_n;

  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_ff <= `SPIDG_RST_FRAME;
    end
    else if (!frame_select_n)
    begin
      if (bit_cnt_ff == '0)
      begin
        shift_ff <= {resp_ff[`SPIDG_FRAME_BITS-2:0], sdi};
      end
      else
      begin
        shift_ff <= {shift_ff[`SPIDG_FRAME_BITS-2:0], sdi};
      end
    end
  end

  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      bit_cnt_ff <= '0;
    end
    else if (bit_cnt_ff != `SPIDG_CNT_FULL)
    begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end
  end

  // forty bits seen flag
  // the counter clears with select, so the core needs a copy that holds
  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      full_ff <= 1'b0;
    end
    else if (!frame_select_n)
    begin
      full_ff <= (bit_cnt_ff >= (`SPIDG_CNT_FULL - 6'h01));
    end
  end

  always_ff @(negedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      sdo_ff <= 1'b0;
    end
    else if (!frame_select_n)
    begin
      sdo_ff <= (bit_cnt_ff == '0) ? resp_ff[`SPIDG_WR_BIT] : shift_ff[`SPIDG_WR_BIT];
    end
  end

  assign sdo_out = sdo_ff;

  // ----------------------------------------
  // core domain: select synchroniser
  // ----------------------------------------
  logic sel_meta_ff;
  logic sel_sync_ff;
  logic sel_prev_ff;
  logic frame_end;
  logic frame_full;
  logic sdo_oe_ff;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_meta_ff <= 1'b1;
      sel_sync_ff <= 1'b1;
      sel_prev_ff <= 1'b1;
      sdo_oe_ff <= 1'b0;
    end
    else
    begin
      sel_meta_ff <= frame_select_n;
      sel_sync_ff <= sel_meta_ff;
      sel_prev_ff <= sel_sync_ff;
      sdo_oe_ff <= !sel_sync_ff;
    end
  end

  assign sdo_oe = sdo_oe_ff;

  // shift_ff and full_ff are frozen while select is high
  assign frame_end = sel_sync_ff && !sel_prev_ff;
  assign frame_full = full_ff;

  // ----------------------------------------
  // command buffering
  // ----------------------------------------
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  spidg_pkg::spidg_frame_t fifo_out_data;

  assign fifo_in_valid = frame_end && frame_full;

  spidg_fifo #(
    .WIDTH(`SPIDG_FRAME_BITS),
    .DEPTH(`SPIDG_FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(shift_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  logic cmd_valid_ff;
  logic cmd_write_ff;
  spidg_pkg::spidg_addr_t cmd_addr_ff;
  spidg_pkg::spidg_word_t cmd_data_ff;
  logic gclr_ff;
  logic drop_ff;
  logic busy_ff;

  assign fifo_out_ready = !cmd_valid_ff || cmd_ready;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_valid_ff <= 1'b0;
      cmd_write_ff <= 1'b0;
      cmd_addr_ff <= '0;
      cmd_data_ff <= `SPIDG_RST_DATA;
    end
    else if (fifo_out_ready)
    begin
      cmd_valid_ff <= fifo_out_valid;
      cmd_write_ff <= fifo_out_data[`SPIDG_WR_BIT];
      cmd_addr_ff <= fifo_out_data[`SPIDG_ADDR_HI:`SPIDG_ADDR_LO];
      cmd_data_ff <= fifo_out_data[`SPIDG_WR_BIT] ?
        fifo_out_data[`SPIDG_DATA_BITS-1:0] : `SPIDG_RST_DATA;
    end
  end

  assign cmd_valid = cmd_valid_ff;
  assign cmd_write = cmd_write_ff;
  assign cmd_addr = cmd_addr_ff;
  assign cmd_data = cmd_data_ff;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gclr_ff <= 1'b0;
      drop_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      gclr_ff <= cmd_valid_ff && cmd_ready && !cmd_write_ff &&
        (cmd_addr_ff == `SPIDG_GLOBAL_STATUS_WORD_ADDR);
      drop_ff <= frame_end && frame_full && !fifo_in_ready;
      busy_ff <= !fifo_in_ready;
    end
  end

  assign global_status_clear = gclr_ff;
  assign frame_dropped = drop_ff;
  assign port_busy = busy_ff;

  // ----------------------------------------
  // response word
  // ----------------------------------------
  spidg_pkg::spidg_status_t status_now;
  spidg_pkg::spidg_status_t status_ff;
  spidg_pkg::spidg_word_t data_ff;
  logic [`SPIDG_OUTST_W-1:0] outst_ff;
  logic pending_ff;
  logic rsp_ready_ff;
  logic rsp_take;
  logic rd_push;

  always_comb
  begin
    status_now = `SPIDG_RST_STATUS;
    status_now[`SPIDG_ST_STOP_R] = motion_status_word[`SPIDG_MS_STOP_R];
    status_now[`SPIDG_ST_STOP_L] = motion_status_word[`SPIDG_MS_STOP_L];
    status_now[`SPIDG_ST_POS] = motion_status_word[`SPIDG_MS_POS];
    status_now[`SPIDG_ST_VEL] = motion_status_word[`SPIDG_MS_VEL];
    status_now[`SPIDG_ST_STILL] = driver_status_word[`SPIDG_DS_STILL];
    status_now[`SPIDG_ST_STALL] = driver_status_word[`SPIDG_DS_STALL];
    status_now[`SPIDG_ST_DRVERR] = global_status_word[`SPIDG_GS_DRVERR];
    status_now[`SPIDG_ST_RESET] = global_status_word[`SPIDG_GS_RESET];
  end

  // answers only accepted between frames, so resp_ff is still for the link
  assign rsp_take = rsp_valid && rsp_ready_ff;
  assign rd_push = fifo_in_valid && fifo_in_ready && !shift_ff[`SPIDG_WR_BIT];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_ready_ff <= 1'b0;
      outst_ff <= '0;
    end
    else
    begin
      rsp_ready_ff <= sel_sync_ff && !frame_end;
      case ({rd_push, rsp_take && (outst_ff != '0)})
        2'b10: outst_ff <= outst_ff + 1'b1;
        2'b01: outst_ff <= outst_ff - 1'b1;
        default: outst_ff <= outst_ff;
      endcase
    end
  end

  assign rsp_ready = rsp_ready_ff;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_ff <= `SPIDG_RST_STATUS;
    end
    else if (frame_end)
    begin
      status_ff <= status_now;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_ff <= `SPIDG_RST_DATA;
      pending_ff <= 1'b0;
    end
    else if (fifo_in_valid && fifo_in_ready)
    begin
      if (shift_ff[`SPIDG_WR_BIT])
      begin
        data_ff <= shift_ff[`SPIDG_DATA_BITS-1:0];
        pending_ff <= 1'b0;
      end
      else
      begin
        data_ff <= `SPIDG_RST_DATA;
        pending_ff <= 1'b1;
      end
    end
    else if (rsp_take && pending_ff && (outst_ff == `SPIDG_OUTST_W'(1)))
    begin
      data_ff <= rsp_hit ? rsp_data : `SPIDG_RST_DATA;
      pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_ff <= `SPIDG_RST_FRAME;
    end
    else if (sel_sync_ff && sel_prev_ff)
    begin
      resp_ff <= {status_ff, data_ff};
    end
  end

endmodule
`default_nettype wire

// >>> verif/spidg_port_sva.sv
`default_nettype none
module spidg_port_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic frame_select_n,
  input wire logic sdo_oe,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [6:0] cmd_addr,
  input wire logic [31:0] cmd_data,
  input wire logic rsp_ready,
  input wire logic global_status_clear,
  input wire logic frame_dropped,
  input wire logic port_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // --
  // port checks
  // --
  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_write, cmd_addr, cmd_data});
  endproperty
  a_hold: assert property (p_hold)
    else $error("command moved before taken");
  property p_rd_zero;
    cmd_valid && !cmd_write |-> cmd_data == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read carries data");
  property p_gclr;
    cmd_valid && cmd_ready && !cmd_write && cmd_addr == 7'h01 |=> global_status_clear;
  endproperty
  a_gclr: assert property (p_gclr)
    else $error("no global clear");
  property p_oe_on;
    !frame_select_n [*5] |-> sdo_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output not driven in frame");
  property p_oe_off;
    frame_select_n [*5] |-> !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven outside frame");
  property p_rsp_lo;
    !frame_select_n [*5] |-> !rsp_ready;
  endproperty
  a_rsp_lo: assert property (p_rsp_lo)
    else $error("answer taken in frame");
  property p_busy;
    port_busy |-> cmd_valid;
  endproperty
  a_busy: assert property (p_busy)
    else $error("full without command");
  property p_drop;
    frame_dropped |=> !frame_dropped;
  endproperty
  a_drop: assert property (p_drop)
    else $error("drop flag held too long");
endmodule
bind spidg_port spidg_port_sva u_sva (.core_clk, .resetn, .frame_select_n, .sdo_oe,
  .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_data, .rsp_ready,
  .global_status_clear, .frame_dropped, .port_busy);
`default_nettype wire

// >>> verif/spidg_host.sv
`default_nettype none
module spidg_host (
  output var logic sck,
  output var logic frame_select_n,
  output var logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b1;
    frame_select_n = 1'b1;
    sdi = 1'b0;
  end
  // --
  // frame transfer
  // --
  // msb first
  task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    #3.3;
    frame_select_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      sck = 1'b0;
      sdi = tx[i];
      #62.5;
      sck = 1'b1;
      rx = {rx[46:0], sdo};
      #62.5;
    end
    frame_select_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule
`default_nettype wire

// >>> verif/spidg_port_tb.sv
`default_nettype none
module spidg_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, cmd_ready, rsp_valid, rsp_hit, seen_drop;
  logic [31:0] rsp_data, ds, mem [128], sh [128];
  logic [9:0] ms;
  logic [1:0] gs;
  logic [39:0] ex;
  logic [47:0] rx;
  int failures, checked;
  wire sck, frame_select_n, sdi, sdo_out, sdo_oe, cmd_valid, cmd_write, rsp_ready;
  wire global_status_clear, frame_dropped, port_busy;
  wire [6:0] cmd_addr;
  wire [31:0] cmd_data;
  wire sdo = sdo_oe ? sdo_out : 1'bz;
  spidg_host u_host (.sck, .frame_select_n, .sdi, .sdo);
  spidg_port u_dut (.core_clk, .resetn, .sck, .frame_select_n, .sdi, .sdo_out, .sdo_oe,
    .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_data, .rsp_valid, .rsp_ready,
    .rsp_hit, .rsp_data, .motion_status_word(ms), .driver_status_word(ds),
    .global_status_word(gs), .global_status_clear, .frame_dropped, .port_busy);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // --
  // register file
  // --
  always @(posedge core_clk)
  begin
    if (cmd_valid && cmd_ready)
    begin
      if (cmd_write)
        mem[cmd_addr] <= cmd_data;
      else
      begin
        rsp_valid <= 1'b1;
        rsp_hit <= cmd_addr < 7'h40;
        rsp_data <= mem[cmd_addr];
      end
    end
    else if (rsp_valid && rsp_ready)
      rsp_valid <= 1'b0;
    if (global_status_clear)
      gs <= 2'h0;
    if (frame_dropped)
      seen_drop <= 1'b1;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] want);
    checked++;
    if (got !== want)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one frame, then next response expected
  task automatic fr(input logic [47:0] tx, input int n, input bit c);
    u_host.xfer(tx, n, rx);
    if (c)
      chk(n == 48 ? rx[47:8] : rx[39:0], ex);
    ex[39:32] = {ms[1], ms[0], ms[9], ms[8], ds[31], ds[24], gs};
    if (tx[39])
    begin
      sh[tx[38:32]] = tx[31:0];
      ex[31:0] = tx[31:0];
    end
    else
      ex[31:0] = tx[38:32] < 7'h40 ? sh[tx[38:32]] : 32'h0;
    repeat (30) @(posedge core_clk);
  endtask
  initial
  begin
    #300000;
    failures++;
    stop_test;
  end
  initial
  begin
    resetn = 1'b0;
    cmd_ready = 1'b1;
    rsp_valid = 1'b0;
    rsp_hit = 1'b0;
    rsp_data = 32'h0;
    seen_drop = 1'b0;
    ms = 10'h201;
    ds = 32'h8000_0000;
    gs = 2'h3;
    ex = 40'h0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    fr(48'h81_00AB_CDEF, 40, 1'b1);
    fr(48'h85_1234_5678, 40, 1'b1);
    fr(48'h05_FFFF_FFFF, 40, 1'b1);
    ms <= 10'h102;
    ds <= 32'h0100_0000;
    fr(48'h01_0000_0000, 40, 1'b1);
    fr(48'h50_0000_0000, 40, 1'b1);
    fr(48'hC3_86_CAFE_F00D, 48, 1'b1);
    chk({32'h0, rx[7:0]}, 40'hC3);
    fr(48'h06_0000_0000, 40, 1'b1);
    u_host.xfer(48'h0000_0000_8F12, 16, rx);
    chk({24'h0, rx[15:0]}, {24'h0, ex[39:24]});
    repeat (30) @(posedge core_clk);
    @(posedge core_clk);
    cmd_ready <= 1'b0;
    for (int i = 0; i < 10; i++)
      fr({8'h00, 8'h90 + 8'(i), 32'(i)}, 40, 1'b1);
    chk({39'h0, port_busy}, 40'h1);
    chk({39'h0, seen_drop}, 40'h1);
    @(posedge core_clk);
    cmd_ready <= 1'b1;
    fr(48'h17_0000_0000, 40, 1'b0);
    fr(48'h17_0000_0000, 40, 1'b1);
    chk({39'h0, port_busy}, 40'h0);
    stop_test;
  end
endmodule
`default_nettype wire
